// >>> hw/vpd_i2c_engine.sv
package vpd_pkg;
  // ****************************************
  // timing
  // ****************************************
  localparam int unsigned CLK_PERIOD_NS = 5;
  localparam int unsigned I2C_QUARTER_NS = 2500;
  localparam int unsigned QUARTER_CYCLES = I2C_QUARTER_NS / CLK_PERIOD_NS;
  localparam logic [9:0] QCNT_LAST = 10'(QUARTER_CYCLES - 1);
  localparam logic [3:0] ACK_BIT = 4'h8;
  // ****************************************
  // eeprom addressing
  // ****************************************
  localparam logic [6:0] EEPROM_SLAVE = 7'h50;
  localparam logic [7:0] CTRL_WR = {EEPROM_SLAVE, 1'b0};
  localparam logic [7:0] CTRL_RD = {EEPROM_SLAVE, 1'b1};
  localparam logic [7:0] RD_BASE_OFS = 8'h07;
  localparam logic [7:0] PG1_BASE_OFS = 8'h07;
  localparam logic [7:0] PG2_BASE_OFS = 8'h05;
  localparam logic [7:0] ADDR_INVERT = 8'hff;
  // ****************************************
  // sequence steps
  // ****************************************
  localparam logic [4:0] RD_FIRST_RX = 5'h05;
  localparam logic [4:0] RD_LAST_RX = 5'h08;
  localparam logic [4:0] RD_LAST_STEP = 5'h09;
  localparam logic [4:0] WR_POLL1 = 5'h07;
  localparam logic [4:0] WR_POLL2 = 5'h0f;
  localparam logic [4:0] WR_LAST_STEP = 5'h10;

  typedef enum logic [2:0] {
    OP_NONE = 3'b000,
    OP_START = 3'b001,
    OP_STOP = 3'b010,
    OP_WRITE = 3'b011,
    OP_READ = 3'b100
  } i2c_op_t;

  typedef enum logic [3:0] {
    SEL_NONE = 4'b0000,
    SEL_CTRL_W = 4'b0001,
    SEL_CTRL_R = 4'b0010,
    SEL_BASE_RD = 4'b0011,
    SEL_BASE1 = 4'b0100,
    SEL_BASE2 = 4'b0101,
    SEL_D3 = 4'b0110,
    SEL_D2 = 4'b0111,
    SEL_D1 = 4'b1000,
    SEL_D0 = 4'b1001
  } byte_sel_t;

  typedef struct packed {
    i2c_op_t op;
    logic [7:0] tx;
    logic ack_out;
  } eng_cmd_t;

  typedef struct packed {
    logic done;
    logic nack;
    logic [7:0] rx;
  } eng_rsp_t;

  typedef struct packed {
    logic wr;
    logic flag;
    logic [14:0] addr;
  } cap_wr_t;
endpackage

module i2c_byte_engine #(
  parameter int unsigned QUARTER_LEN = vpd_pkg::QUARTER_CYCLES
) (
  input wire logic ref_clk,
  input wire logic srst,
  input wire logic clk_en,
  input wire logic cmd_valid,
  input wire vpd_pkg::eng_cmd_t cmd,
  input wire logic sda_in,
  output vpd_pkg::eng_rsp_t rsp,
  output logic scl_oe,
  output logic sda_oe
);
  import vpd_pkg::*;

  // qcnt is ten bits wide, so a quarter may span at most 1024 clocks
  localparam logic [9:0] QCNT_END = 10'(QUARTER_LEN - 1);

  typedef struct packed {
    i2c_op_t op;
    logic [9:0] qcnt;
    logic [1:0] qtr;
    logic [3:0] bitn;
    logic [8:0] sh;
    logic scl_oe;
    logic sda_oe;
    eng_rsp_t rsp;
  } eng_state_t;

  eng_state_t q, d;

  always_comb begin
    d = q;
    d.rsp.done = 1'b0;
    if (q.op == OP_NONE) begin
      if (cmd_valid) begin
        d.op = cmd.op;
        d.qcnt = '0;
        d.qtr = '0;
        d.bitn = '0;
        d.rsp.nack = 1'b0;
        // ninth bit: released for slave ack, or master ack/nack on reads
        d.sh = (cmd.op == OP_READ) ? {8'hff, ~cmd.ack_out} : {cmd.tx, 1'b1};
      end
    end else if (q.qcnt != QCNT_END) begin
      d.qcnt = q.qcnt + 10'h001;
    end else begin
      d.qcnt = '0;
      d.qtr = q.qtr + 2'h1;
      unique case (q.op)
        OP_START: begin
          // also serves as repeated start: scl is low on entry
          unique case (q.qtr)
            2'h0: d.sda_oe = 1'b0;
            2'h1: d.scl_oe = 1'b0;
            2'h2: d.sda_oe = 1'b1;
            2'h3: begin
              d.scl_oe = 1'b1;
              d.op = OP_NONE;
              d.rsp.done = 1'b1;
            end
          endcase
        end
        OP_STOP: begin
          unique case (q.qtr)
            2'h0: d.sda_oe = 1'b1;
            2'h1: d.scl_oe = 1'b0;
            2'h2: d.sda_oe = 1'b0;
            2'h3: begin
              d.op = OP_NONE;
              d.rsp.done = 1'b1;
            end
          endcase
        end
        default: begin
          unique case (q.qtr)
            2'h0: d.sda_oe = ~q.sh[8];
            2'h1: d.scl_oe = 1'b0;
            2'h2: begin
              if (q.bitn == ACK_BIT) begin
                d.rsp.nack = (q.op == OP_WRITE) & sda_in;
              end else begin
                d.rsp.rx = {q.rsp.rx[6:0], sda_in};
              end
            end
            2'h3: begin
              d.scl_oe = 1'b1;
              d.sh = {q.sh[7:0], 1'b1};
              d.bitn = q.bitn + 4'h1;
              if (q.bitn == ACK_BIT) begin
                // release data while scl is low so the next op starts clean
                d.sda_oe = 1'b0;
                d.op = OP_NONE;
                d.rsp.done = 1'b1;
              end
            end
          endcase
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      q <= '0;
    end else if (clk_en) begin
      q <= d;
    end
  end

  assign rsp = q.rsp;
  assign scl_oe = q.scl_oe;
  assign sda_oe = q.sda_oe;

  // sda may only change with scl high inside start or stop
  sda_edge_a: assert property (@(posedge ref_clk) disable iff (srst)
    $changed(q.sda_oe) && !q.scl_oe |-> q.op == OP_START || q.op == OP_STOP)
    else $error("sda changed with scl high outside start or stop");
endmodule // i2c_byte_engine

// >>> hw/vpd_eeprom_access.sv
module vpd_eeprom_access #(
  // quarter of an scl bit in clocks; the default gives 2.5 us quarters
  parameter int unsigned QUARTER_LEN = vpd_pkg::QUARTER_CYCLES
) (
  input wire logic ref_clk,
  input wire logic srst,
  input wire logic clk_en,
  input wire vpd_pkg::cap_wr_t cap,
  input wire logic [3:0] data_be,
  input wire logic [31:0] data_wdata,
  input wire logic bus_busy,
  input wire logic sda_in,
  output logic scl_out,
  output logic scl_oe,
  output logic sda_out,
  output logic sda_oe,
  output logic vpd_flag,
  output logic [31:0] vpd_data,
  output logic seq_busy,
  output logic seq_done
);
  import vpd_pkg::*;

  typedef enum logic [1:0] {
    S_IDLE = 2'b00,
    S_WAIT_BUS = 2'b01,
    S_ISSUE = 2'b10,
    S_WAIT_ENG = 2'b11
  } seq_state_t;

  typedef struct packed {
    i2c_op_t op;
    byte_sel_t sel;
  } step_t;

  typedef struct packed {
    seq_state_t st;
    logic wr;
    logic abort;
    logic [4:0] step;
    logic [7:0] addr_lo;
    logic flag;
    logic [31:0] data;
    logic busy;
    logic done;
    logic cmd_valid;
    eng_cmd_t cmd;
  } seq_q_t;

  seq_q_t q, d;
  eng_rsp_t rsp;
  step_t cur;

  // ****************************************
  // sequence tables
  // ****************************************
  function automatic step_t step_decode(input logic wr, input logic [4:0] step);
    step_t s;
    s = '{op: OP_NONE, sel: SEL_NONE};
    if (!wr) begin
      unique case (step)
        5'h00: s = '{op: OP_START, sel: SEL_NONE};
        5'h01: s = '{op: OP_WRITE, sel: SEL_CTRL_W};
        5'h02: s = '{op: OP_WRITE, sel: SEL_BASE_RD};
        5'h03: s = '{op: OP_START, sel: SEL_NONE};
        5'h04: s = '{op: OP_WRITE, sel: SEL_CTRL_R};
        5'h05, 5'h06, 5'h07, 5'h08: s = '{op: OP_READ, sel: SEL_NONE};
        5'h09: s = '{op: OP_STOP, sel: SEL_NONE};
        default: s = '{op: OP_NONE, sel: SEL_NONE};
      endcase
    end else begin
      unique case (step)
        5'h00, 5'h06, 5'h08, 5'h0e: s = '{op: OP_START, sel: SEL_NONE};
        5'h01, 5'h07, 5'h09, 5'h0f: s = '{op: OP_WRITE, sel: SEL_CTRL_W};
        5'h02: s = '{op: OP_WRITE, sel: SEL_BASE1};
        5'h03: s = '{op: OP_WRITE, sel: SEL_D3};
        5'h04: s = '{op: OP_WRITE, sel: SEL_D2};
        5'h05, 5'h0d, 5'h10: s = '{op: OP_STOP, sel: SEL_NONE};
        5'h0a: s = '{op: OP_WRITE, sel: SEL_BASE2};
        5'h0b: s = '{op: OP_WRITE, sel: SEL_D1};
        5'h0c: s = '{op: OP_WRITE, sel: SEL_D0};
        default: s = '{op: OP_NONE, sel: SEL_NONE};
      endcase
    end
    return s;
  endfunction

  // inverted addressing puts lower logical addresses at higher locations
  function automatic logic [7:0] byte_of(input byte_sel_t sel, input logic [7:0] lo,
                                         input logic [31:0] data);
    logic [7:0] b;
    b = 8'h00;
    unique case (sel)
      SEL_CTRL_W: b = CTRL_WR;
      SEL_CTRL_R: b = CTRL_RD;
      SEL_BASE_RD: b = (lo + RD_BASE_OFS) ^ ADDR_INVERT;
      SEL_BASE1: b = (lo + PG1_BASE_OFS) ^ ADDR_INVERT;
      SEL_BASE2: b = (lo + PG2_BASE_OFS) ^ ADDR_INVERT;
      SEL_D3: b = data[31:24];
      SEL_D2: b = data[23:16];
      SEL_D1: b = data[15:8];
      SEL_D0: b = data[7:0];
      SEL_NONE: b = 8'h00;
      default: b = 8'h00;
    endcase
    return b;
  endfunction

  // ****************************************
  // sequencer
  // ****************************************
  assign cur = step_decode(q.wr, q.step);

  always_comb begin
    logic [4:0] last;
    last = q.wr ? WR_LAST_STEP : RD_LAST_STEP;
    d = q;
    d.cmd_valid = 1'b0;
    d.done = 1'b0;
    unique case (q.st)
      S_IDLE: begin
        for (int i = 0; i < 4; i++) begin
          if (data_be[i]) begin
            d.data[8*i +: 8] = data_wdata[8*i +: 8];
          end
        end
        if (cap.wr) begin
          d.addr_lo = cap.addr[7:0];
          d.flag = cap.flag;
          d.wr = cap.flag;
          d.step = '0;
          d.abort = 1'b0;
          d.st = S_WAIT_BUS;
        end
      end
      S_WAIT_BUS: begin
        // another master owns the shared bus; hold off until it lets go
        if (!bus_busy) begin
          d.busy = 1'b1;
          d.st = S_ISSUE;
        end
      end
      S_ISSUE: begin
        d.cmd.op = cur.op;
        d.cmd.tx = byte_of(cur.sel, q.addr_lo, q.data);
        d.cmd.ack_out = (q.step != RD_LAST_RX);
        d.cmd_valid = 1'b1;
        d.st = S_WAIT_ENG;
      end
      S_WAIT_ENG: begin
        if (rsp.done) begin
          d.st = S_ISSUE;
          if (cur.op == OP_READ) begin
            unique case (q.step[1:0])
              2'h1: d.data[31:24] = rsp.rx;
              2'h2: d.data[23:16] = rsp.rx;
              2'h3: d.data[15:8] = rsp.rx;
              2'h0: d.data[7:0] = rsp.rx;
            endcase
          end
          if (cur.op == OP_WRITE && rsp.nack) begin
            if (q.wr && (q.step == WR_POLL1 || q.step == WR_POLL2)) begin
              d.step = q.step - 5'h01;
            end else begin
              // stop to free the bus; flag untouched
              d.abort = 1'b1;
              d.step = last;
            end
          end else if (q.step == last) begin
            d.st = S_IDLE;
            d.busy = 1'b0;
            d.done = 1'b1;
            if (!q.abort) begin
              d.flag = ~q.wr;
            end
          end else begin
            d.step = q.step + 5'h01;
          end
        end
      end
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      q <= '0;
    end else if (clk_en) begin
      q <= d;
    end
  end

  i2c_byte_engine #(
    .QUARTER_LEN(QUARTER_LEN)
  ) u_engine (
    .ref_clk(ref_clk),
    .srst(srst),
    .clk_en(clk_en),
    .cmd_valid(q.cmd_valid),
    .cmd(q.cmd),
    .sda_in(sda_in),
    .rsp(rsp),
    .scl_oe(scl_oe),
    .sda_oe(sda_oe)
  );

  // open-drain pins only ever pull low
  assign scl_out = 1'b0;
  assign sda_out = 1'b0;
  assign vpd_flag = q.flag;
  assign vpd_data = q.data;
  assign seq_busy = q.busy;
  assign seq_done = q.done;

  // ****************************************
  // checks
  // ****************************************
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (srst);

  bus_idle_start_a: assert property ($rose(q.busy) |-> $past(!bus_busy))
    else $error("sequence started while shared bus busy");
  read_flag_set_a: assert property ($fell(q.busy) && !q.wr && !q.abort |-> q.flag)
    else $error("read finished without setting flag");
  write_flag_clr_a: assert property ($fell(q.busy) && q.wr && !q.abort |-> !q.flag)
    else $error("write finished without clearing flag");
  read_abort_flag_a: assert property ($fell(q.busy) && !q.wr && q.abort |-> !q.flag)
    else $error("aborted read set the flag");
  write_abort_flag_a: assert property ($fell(q.busy) && q.wr && q.abort |-> q.flag)
    else $error("aborted write cleared the flag");
  ctrl_byte_a: assert property (q.cmd_valid && q.step == 5'h01 |-> q.cmd.tx == 8'ha0)
    else $error("wrong eeprom control byte");
  page2_base_a: assert property (q.cmd_valid && q.wr && q.step == 5'h0a
    |-> q.cmd.tx == ~(q.addr_lo + 8'h05))
    else $error("second page base address wrong");
  poll_retry_a: assert property (q.st == S_WAIT_ENG && rsp.done && rsp.nack
    && q.wr && q.step == WR_POLL1 |=> q.step == 5'h06 ##1 q.cmd_valid)
    else $error("ack poll did not retry with start");
endmodule // vpd_eeprom_access

// >>> verification/eeprom_model.sv
// ****************************************
// serial eeprom on the shared two-wire bus
// ****************************************
// busy_polls sets how many control bytes are refused after a write
module eeprom_model (
  input wire logic ref_clk,
  input wire logic scl,
  input wire logic sda,
  input wire logic absent,
  input wire logic [3:0] busy_polls,
  output logic sda_pull
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] mem [256];
  logic scl_q, sda_q, sel_q, rd_q;
  logic [3:0] bit_q, busy_q;
  logic [7:0] sh_q, tx_q, ptr_q;
  int nbyte_q, nack_cnt;
  wire logic ok = !absent && busy_q == 4'h0 && sh_q[7:1] == 7'h50;
  initial begin
    {sda_pull, sel_q, rd_q, bit_q, busy_q, ptr_q, nbyte_q, nack_cnt} = '0;
    {scl_q, sda_q} = 2'h3;
  end
  always @(posedge ref_clk) begin
    scl_q <= scl;
    sda_q <= sda;
    if (scl && scl_q && sda_q && !sda) begin
      {bit_q, nbyte_q, sel_q, rd_q, sda_pull} <= '0;
    end else if (scl && scl_q && !sda_q && sda) begin
      // programming starts only once the byte write is closed
      if (sel_q && !rd_q && nbyte_q > 2) busy_q <= busy_polls;
      sel_q <= 1'b0;
    end else if (scl && !scl_q) begin
      if (bit_q < 8) sh_q <= {sh_q[6:0], sda};
      else if (rd_q && nbyte_q > 0 && sda) sel_q <= 1'b0;
      bit_q <= bit_q + 4'h1;
    end else if (!scl && scl_q) begin
      case (bit_q)
        4'h8: begin
          if (nbyte_q == 0) begin
            if (busy_q != 0) begin
              busy_q <= busy_q - 4'h1;
              nack_cnt <= nack_cnt + 1;
            end
            sel_q <= ok;
            rd_q <= sh_q[0];
            sda_pull <= ok;
          end else if (!rd_q) begin
            if (nbyte_q == 1) ptr_q <= sh_q;
            else if (sel_q) begin
              mem[ptr_q] <= sh_q;
              ptr_q <= ptr_q + 8'h1;
            end
            sda_pull <= sel_q;
          end else sda_pull <= 1'b0;
        end
        4'h9: begin
          bit_q <= 4'h0;
          nbyte_q <= nbyte_q + 1;
          sda_pull <= rd_q && sel_q && !mem[ptr_q][7];
          if (rd_q && sel_q) begin
            tx_q <= mem[ptr_q];
            ptr_q <= ptr_q + 8'h1;
          end
        end
        default: begin
          if (bit_q != 0 && rd_q && nbyte_q > 0 && sel_q) begin
            sda_pull <= !tx_q[6];
            tx_q <= tx_q << 1;
          end
        end
      endcase
    end
  end
endmodule // eeprom_model

// >>> verification/testbench.sv
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  import vpd_pkg::*;
  logic ref_clk, srst, clk_en, bus_busy, absent, sda_pull;
  cap_wr_t cap;
  logic [3:0] data_be, busy_polls;
  logic [31:0] data_wdata, vpd_data;
  logic scl_oe, sda_oe, vpd_flag, seq_busy, seq_done, scl_out, sda_out;
  int bad_count, n_tests;
  // open-drain lines with pull-ups
  wire logic scl = !scl_oe;
  wire logic sda = !(sda_oe || sda_pull);

  // short quarters keep the run small; the sequence does not depend on the bit rate
  vpd_eeprom_access #(.QUARTER_LEN(8)) dut (.ref_clk(ref_clk), .srst(srst), .clk_en(clk_en),
    .cap(cap), .data_be(data_be), .data_wdata(data_wdata), .bus_busy(bus_busy), .sda_in(sda),
    .scl_out(scl_out), .scl_oe(scl_oe), .sda_out(sda_out), .sda_oe(sda_oe), .vpd_flag(vpd_flag),
    .vpd_data(vpd_data), .seq_busy(seq_busy), .seq_done(seq_done));
  eeprom_model ee (.ref_clk(ref_clk), .scl(scl), .sda(sda), .absent(absent),
    .busy_polls(busy_polls), .sda_pull(sda_pull));

  // ****************************************
  // helpers
  // ****************************************
  task automatic cyc(int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask
  task automatic check(string name, logic [31:0] exp, logic [31:0] got);
    n_tests++;
    if (got !== exp) begin
      $display("[FAIL] %s expected %h seen %h", name, exp, got);
      bad_count++;
    end
  endtask
  task automatic cap_wr(logic f, logic [14:0] a);
    cap = {1'b1, f, a};
    cyc(1);
    cap.wr = 1'b0;
    cyc(1);
  endtask
  task automatic byte_wr(int lane, logic [7:0] v);
    data_be = 4'h1 << lane;
    data_wdata = {4{v}};
    cyc(1);
    data_be = 4'h0;
    cyc(1);
  endtask
  task automatic wait_done();
    int n;
    n = 0;
    while (seq_done !== 1'b1 && n < 20000) begin
      cyc(1);
      n++;
    end
    if (n == 20000) begin
      check("done_seen", 32'h1, 32'h0);
      test_done();
    end
  endtask
  task automatic test_done();
    if (bad_count == 0 && n_tests > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  // ****************************************
  // scenarios
  // ****************************************
  task automatic t_read_base();
    {ee.mem[8'hf8], ee.mem[8'hf9], ee.mem[8'hfa], ee.mem[8'hfb]} = 32'h11223344;
    bus_busy = 1'b1;
    cap_wr(1'b0, 15'h0000);
    check("flag_clear", 32'h0, vpd_flag);
    cyc(40);
    check("bus_wait", 32'h0, {seq_busy, scl_oe, sda_oe});
    bus_busy = 1'b0;
    cyc(3);
    check("bus_taken", 32'h1, seq_busy);
    wait_done();
    check("rd_flag", 32'h1, vpd_flag);
    check("rd_data", 32'h11223344, vpd_data);
  endtask
  task automatic t_write();
    byte_wr(3, 8'ha1);
    byte_wr(2, 8'hb2);
    byte_wr(1, 8'hc3);
    byte_wr(0, 8'hd4);
    check("data_bytes", 32'ha1b2c3d4, vpd_data);
    busy_polls = 4'h3;
    cap_wr(1'b1, 15'h7ef7);
    check("flag_set", 32'h1, vpd_flag);
    cyc(10);
    cap_wr(1'b0, 15'h0000);
    check("busy_refused", 32'h1, vpd_flag);
    byte_wr(0, 8'h5a);
    check("data_refused", 32'ha1b2c3d4, vpd_data);
    wait_done();
    check("wr_flag", 32'h0, vpd_flag);
    check("wr_bytes", 32'ha1b2c3d4, {ee.mem[1], ee.mem[2], ee.mem[3], ee.mem[4]});
    check("poll_nacks", 32'h6, ee.nack_cnt);
  endtask
  task automatic t_read_back();
    cap_wr(1'b0, 15'h00f7);
    wait_done();
    check("rb_data", 32'ha1b2c3d4, vpd_data);
  endtask
  task automatic t_read_abort();
    absent = 1'b1;
    cap_wr(1'b0, 15'h0010);
    wait_done();
    check("rd_abort", 32'h0, vpd_flag);
    cyc(2);
    check("released", 32'h0, {scl_oe, sda_oe});
  endtask
  task automatic t_write_abort();
    cap_wr(1'b1, 15'h0010);
    wait_done();
    check("wr_abort", 32'h1, vpd_flag);
    absent = 1'b0;
  endtask

  initial begin
    ref_clk = 1'b0;
    forever #2.5 ref_clk = !ref_clk;
  end
  // a full run is near 10k cycles; the limit leaves more than three times that
  initial begin
    #200000;
    bad_count++;
    test_done();
  end
  initial begin
    {srst, clk_en} = 2'h3;
    {bus_busy, absent, data_be, data_wdata, busy_polls, bad_count, n_tests} = '0;
    cap = '0;
    cyc(20);
    srst = 1'b0;
    check("reset_out", 32'h0, {vpd_flag, seq_busy, scl_oe, sda_oe, seq_done, scl_out, sda_out});
    t_read_base();
    t_write();
    t_read_back();
    t_read_abort();
    t_write_abort();
    test_done();
  end
endmodule // testbench
